// *** hw/lsa_alert.sv ***
// Sticky limit status, alert masking and shared pin control.
`timescale 1ns/1ps

// Operation
// - Out-of-limit comparison sets channel status bit.
// - Status bits stay set until read.
// - Read clears bit only if condition ended.
// - First register bit 7 summarises second register.
// - First register bits 6..0 map channels.
// - Throttle mode: bit 0 reports throttle input.
// - Second register bits 7,6 flag diode faults.
// - Second register bits 4..2 flag slow fans.
// - Bit 5 follows shared pin use.
// - Bit 1 overtemperature; bit 0 twelve/VID.
// - Alert holds while out and unread.
// - Mask blocks alert, status still sets.
// - First mask mirrors; bit 7 masks second.
// - Second mask mirrors; bit 5 follows use.
// - Alert off after reset; select second drive.
// - Configuration four selects shared pin use.
// - Throttle enable picks pin role.
// - Boost: full fans while throttle low.
// - Boost only for already running fan.
// - High above limit, low at-or-below limit.
// - Throttle use with throttle enabled: timer above limit sets bit 5.
module lsa_alert
  import lsa_pkg::*;
#(
  parameter int DATA_W = 8,
  parameter int VID_W = 6
) (
  input wire logic mclk_in,
  input wire logic rst_b_in,
  // Register port from the serial management engine.
  input wire logic [7:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_wdata_in,
  output logic [7:0] reg_rdata_out,
  // Completed measurement with its limits.
  input wire logic meas_valid_in,
  input wire logic [2:0] meas_chan_in,
  input wire logic [DATA_W-1:0] meas_value_in,
  input wire logic [DATA_W-1:0] meas_high_in,
  input wire logic [DATA_W-1:0] meas_low_in,
  // Level conditions from the measurement engine.
  input wire logic diode_two_fault_in,
  input wire logic diode_one_fault_in,
  input wire logic fan_four_slow_in,
  input wire logic fan_three_slow_in,
  input wire logic fan_two_slow_in,
  input wire logic fan_one_slow_in,
  input wire logic critical_overtemp_in,
  input wire logic vid_change_select_in,
  // Throttle timer and its limit.
  input wire logic [7:0] throttle_timer_in,
  input wire logic [7:0] throttle_limit_in,
  // Fan state for the boost response.
  input wire logic manual_mode_in,
  input wire logic [7:0] manual_duty_in,
  input wire logic temp_above_tmin_in,
  input wire logic second_fan_pwm_in,
  // Pins.
  input wire logic thermal_throttle_pin_in,
  input wire logic shared_general_pin_in,
  input wire logic [VID_W-1:0] voltage_id_input_in,
  output logic second_fan_drive_out,
  output logic second_fan_drive_oe_out,
  output logic shared_general_pin_out,
  output logic shared_general_pin_oe_out,
  output logic fan_boost_out,
  output logic shared_tach_sel_out
);

  // ******************************************************************
  // Helpers
  // ******************************************************************
  // Flags whether a register access targets the given offset.
  function automatic logic hits(input logic [7:0] addr,
                                input logic [7:0] off);
    hits = (addr == off);
  endfunction : hits

  // ******************************************************************
  // Declarations
  // ******************************************************************
  localparam int SYNC_W = VID_W + 2;

  logic [SYNC_W-1:0] pins_sync;
  logic throttle_pin_s;
  logic shared_pin_s;
  logic [VID_W-1:0] vid_s;
  logic [VID_W-1:0] vid_prev_q;
  logic [LSA_SYNC_FILL-1:0] vid_primed_q;
  logic vid_change;

  logic [7:0] status_first_q;
  logic [7:0] status_second_q;
  logic [7:0] mask_first_q;
  logic [7:0] mask_second_q;
  logic [7:0] config_three_q;
  logic [7:0] config_four_q;
  logic [LSA_NUM_CHAN-1:0] chan_out_q;
  logic [7:0] reg_rdata_q;
  logic drive_q;
  logic drive_oe_q;
  logic shared_oe_q;
  logic boost_q;

  logic [LSA_NUM_CHAN-1:0] hit;
  logic [LSA_NUM_CHAN-1:0] cond_chan;
  logic out_of_limit;
  lsa_use_e use_mode;
  logic throttle_en;
  logic throttle_main;
  logic throttle_shared;
  logic timer_over;
  logic shared_cond;
  logic [7:0] set_first;
  logic [7:0] cond_first;
  logic [7:0] set_second;
  logic [7:0] cond_second;
  logic clr_first;
  logic clr_second;
  logic fan_running;
  logic alert_level;

  // ******************************************************************
  // Pin synchronisers
  // ******************************************************************
  lsa_sync #(
    .WIDTH(SYNC_W)
  ) u_sync (
    .mclk_in(mclk_in),
    .rst_b_in(rst_b_in),
    .async_in({voltage_id_input_in, shared_general_pin_in,
               thermal_throttle_pin_in}),
    .sync_out(pins_sync)
  );

  // Split the synchronised pin bank.
  assign throttle_pin_s = pins_sync[0];
  assign shared_pin_s = pins_sync[1];
  assign vid_s = pins_sync[SYNC_W-1:2];

  // ******************************************************************
  // Configuration decode
  // ******************************************************************
  // The two function bits are read bit 0 first, then bit 1.
  // shared pin use
  assign use_mode = lsa_use_e'({config_four_q[LSA_C4_FUNC_BIT0],
                                config_four_q[LSA_C4_FUNC_BIT1]});
  assign throttle_en = config_three_q[LSA_C3_THROTTLE_EN];

  // Throttle inputs are active low; the shared pin needs its mode too.
  // throttle pin role
  assign throttle_main = throttle_en & ~throttle_pin_s;
  assign throttle_shared = throttle_en & (use_mode == LSA_USE_THROTTLE)
                           & ~shared_pin_s;

  // Tachometer path is enabled only in the tachometer use.
  assign shared_tach_sel_out = (use_mode == LSA_USE_TACH);

  // ******************************************************************
  // Limit comparison
  // ******************************************************************
  // High limit is strict, low limit includes equality.
  // window compare
  assign out_of_limit = (meas_value_in > meas_high_in)
                        | (meas_value_in <= meas_low_in);

  // One-hot events for the channel that just completed.
  // comparison events
  always_comb begin
    hit = '0;
    if (meas_valid_in && out_of_limit) begin
      hit[meas_chan_in] = 1'b1;
    end
  end

  // Last comparison result per channel forms its live condition.
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      chan_out_q <= '0;
    end else if (meas_valid_in) begin
      chan_out_q[meas_chan_in] <= out_of_limit;
    end
  end

  assign cond_chan = chan_out_q | hit;

  // ******************************************************************
  // Identification code change detection
  // ******************************************************************
  // Changes count only once the synchroniser and the previous copy both
  // hold real pin values, so the synchroniser's reset level is no change.
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      vid_prev_q <= '0;
      vid_primed_q <= '0;
    end else begin
      vid_prev_q <= vid_s;
      vid_primed_q <= {vid_primed_q[LSA_SYNC_FILL-2:0], 1'b1};
    end
  end

  assign vid_change = vid_primed_q[LSA_SYNC_FILL-1]
                      & (vid_s != vid_prev_q);

  // ******************************************************************
  // Status set and condition vectors
  // ******************************************************************
  // timer over limit
  assign timer_over = throttle_timer_in > throttle_limit_in;

  // Bit 5 of the second register follows the shared pin use.
  // shared bit source
  always_comb begin
    case (use_mode)
      LSA_USE_TACH: shared_cond = fan_four_slow_in;
      LSA_USE_THROTTLE: shared_cond = throttle_en & timer_over;
      LSA_USE_GENERAL: shared_cond = shared_pin_s;
      LSA_USE_ALERT: shared_cond = 1'b0;
      default: shared_cond = 1'b0;
    endcase
  end

  // First register: channels 6..0 in bit order, summary bit computed.
  // channel order
  always_comb begin
    set_first = {1'b0, hit[LSA_B1_SUMMARY-1:0]};
    cond_first = {1'b0, cond_chan[LSA_B1_SUMMARY-1:0]};
    if (throttle_en) begin
      set_first[LSA_B1_LOW_VOLT] = throttle_main;
      cond_first[LSA_B1_LOW_VOLT] = throttle_main;
    end
  end

  // Second register: level faults set while present.
  always_comb begin
    set_second = '0;
    set_second[LSA_B2_DIODE_TWO] = diode_two_fault_in;
    set_second[LSA_B2_DIODE_ONE] = diode_one_fault_in;
    set_second[LSA_B2_FAN_FOUR] = shared_cond;
    set_second[LSA_B2_FAN_THREE] = fan_three_slow_in;
    set_second[LSA_B2_FAN_TWO] = fan_two_slow_in;
    set_second[LSA_B2_FAN_ONE] = fan_one_slow_in;
    set_second[LSA_B2_OVERTEMP] = critical_overtemp_in;
    set_second[LSA_B2_TWELVE] = vid_change_select_in ? vid_change
                                : hit[LSA_CH_TWELVE];
  end

  // A code change is an event and leaves no lasting condition.
  always_comb begin
    cond_second = set_second;
    cond_second[LSA_B2_TWELVE] = vid_change_select_in ? vid_change
                                 : cond_chan[LSA_CH_TWELVE];
  end

  // ******************************************************************
  // Sticky status registers
  // ******************************************************************
  assign clr_first = reg_rd_in & hits(reg_addr_in, LSA_OFF_STATUS_FIRST);
  assign clr_second = reg_rd_in & hits(reg_addr_in, LSA_OFF_STATUS_SECOND);

  // A read drops only ended conditions; a new set wins over the clear.
  // sticky bits
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      status_first_q <= LSA_RST_BYTE;
    end else begin
      status_first_q <= (status_first_q & ~({8{clr_first}} & ~cond_first))
                        | set_first;
    end
  end

  // Second register follows the same sticky scheme.
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      status_second_q <= LSA_RST_BYTE;
    end else begin
      status_second_q <= (status_second_q
                          & ~({8{clr_second}} & ~cond_second))
                         | set_second;
    end
  end

  // ******************************************************************
  // Mask and configuration registers
  // ******************************************************************
  // Masks reset to all sources unmasked.
  // reset clears masks
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      mask_first_q <= LSA_RST_BYTE;
      mask_second_q <= LSA_RST_BYTE;
    end else if (reg_wr_in) begin
      if (hits(reg_addr_in, LSA_OFF_MASK_FIRST)) begin
        mask_first_q <= reg_wdata_in;
      end
      if (hits(reg_addr_in, LSA_OFF_MASK_SECOND)) begin
        mask_second_q <= reg_wdata_in;
      end
    end
  end

  // Configuration resets with the alert pin function off.
  // alert disabled at reset
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      config_three_q <= LSA_RST_BYTE;
      config_four_q <= LSA_RST_BYTE;
    end else if (reg_wr_in) begin
      if (hits(reg_addr_in, LSA_OFF_CONFIG_THREE)) begin
        config_three_q <= reg_wdata_in;
      end
      if (hits(reg_addr_in, LSA_OFF_CONFIG_FOUR)) begin
        config_four_q <= reg_wdata_in;
      end
    end
  end

  // ******************************************************************
  // Register read path
  // ******************************************************************
  // Read data is registered; unmapped offsets return zero.
  // summary bit
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      reg_rdata_q <= LSA_RST_BYTE;
    end else if (reg_rd_in) begin
      case (reg_addr_in)
        LSA_OFF_STATUS_FIRST:
          reg_rdata_q <= {|status_second_q,
                          status_first_q[LSA_B1_SUMMARY-1:0]};
        LSA_OFF_STATUS_SECOND: reg_rdata_q <= status_second_q;
        LSA_OFF_MASK_FIRST: reg_rdata_q <= mask_first_q;
        LSA_OFF_MASK_SECOND: reg_rdata_q <= mask_second_q;
        LSA_OFF_CONFIG_THREE: reg_rdata_q <= config_three_q;
        LSA_OFF_CONFIG_FOUR: reg_rdata_q <= config_four_q;
        default: reg_rdata_q <= LSA_RST_BYTE;
      endcase
    end
  end

  assign reg_rdata_out = reg_rdata_q;

  // ******************************************************************
  // Alert generation
  // ******************************************************************
  // Mask bits mirror status bits; first mask bit 7 gates the second.
  // first mask
  assign alert_level =
    (|(status_first_q[LSA_B1_SUMMARY-1:0]
       & ~mask_first_q[LSA_B1_SUMMARY-1:0]))
    | (~mask_first_q[LSA_B1_SUMMARY]
       & (|(status_second_q & ~mask_second_q)));

  // ******************************************************************
  // Pin drivers
  // ******************************************************************
  // Second drive pin: open-drain alert when selected, else fan PWM.
  // drive pin select
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      drive_q <= 1'b0;
      drive_oe_q <= 1'b0;
    end else if (config_three_q[LSA_C3_ALERT_PIN]) begin
      drive_q <= 1'b0;
      drive_oe_q <= alert_level;
    end else begin
      drive_q <= second_fan_pwm_in;
      drive_oe_q <= 1'b1;
    end
  end

  // Shared pin pulls low only in alert use while an alert stands.
  // shared alert driver
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      shared_oe_q <= 1'b0;
    end else begin
      shared_oe_q <= (use_mode == LSA_USE_ALERT) & alert_level;
    end
  end

  assign second_fan_drive_out = drive_q;
  assign second_fan_drive_oe_out = drive_oe_q;
  assign shared_general_pin_out = 1'b0;
  assign shared_general_pin_oe_out = shared_oe_q;

  // ******************************************************************
  // Fan boost
  // ******************************************************************
  // A fan counts as running unless its duty or temperature says idle.
  // running fan only
  assign fan_running = manual_mode_in ? (manual_duty_in != LSA_DUTY_OFF)
                       : temp_above_tmin_in;

  // Boost tracks the throttle low level, one cycle behind.
  // boost on throttle
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      boost_q <= 1'b0;
    end else begin
      boost_q <= config_three_q[LSA_C3_BOOST] & fan_running
                 & (throttle_main | throttle_shared);
    end
  end

  assign fan_boost_out = boost_q;

endmodule : lsa_alert

// *** common/lsa_pkg.sv ***
// Constants shared by the limit status and alert logic.
package lsa_pkg;

  // ******************************************************************
  // Register offsets
  // ******************************************************************
  localparam logic [7:0] LSA_OFF_STATUS_FIRST = 8'h41;
  localparam logic [7:0] LSA_OFF_STATUS_SECOND = 8'h42;
  localparam logic [7:0] LSA_OFF_MASK_FIRST = 8'h74;
  localparam logic [7:0] LSA_OFF_MASK_SECOND = 8'h75;
  localparam logic [7:0] LSA_OFF_CONFIG_THREE = 8'h78;
  localparam logic [7:0] LSA_OFF_CONFIG_FOUR = 8'h7d;

  // ******************************************************************
  // Reset values
  // ******************************************************************
  localparam logic [7:0] LSA_RST_BYTE = 8'h00;

  // ******************************************************************
  // Field positions
  // ******************************************************************
  // First status register.
  localparam int LSA_B1_SUMMARY = 7;
  localparam int LSA_B1_LOW_VOLT = 0;
  // Second status register.
  localparam int LSA_B2_DIODE_TWO = 7;
  localparam int LSA_B2_DIODE_ONE = 6;
  localparam int LSA_B2_FAN_FOUR = 5;
  localparam int LSA_B2_FAN_THREE = 4;
  localparam int LSA_B2_FAN_TWO = 3;
  localparam int LSA_B2_FAN_ONE = 2;
  localparam int LSA_B2_OVERTEMP = 1;
  localparam int LSA_B2_TWELVE = 0;
  // Configuration register three.
  localparam int LSA_C3_ALERT_PIN = 0;
  localparam int LSA_C3_THROTTLE_EN = 1;
  localparam int LSA_C3_BOOST = 2;
  // Configuration register four, shared pin function bits.
  localparam int LSA_C4_FUNC_BIT0 = 0;
  localparam int LSA_C4_FUNC_BIT1 = 1;

  // ******************************************************************
  // Measurement channels and shared pin uses
  // ******************************************************************
  localparam int LSA_NUM_CHAN = 8;
  localparam logic [2:0] LSA_CH_TWELVE = 3'h7;
  localparam logic [7:0] LSA_DUTY_OFF = 8'h00;
  // Edges after reset before a synchronised pin and its copy are real.
  localparam int LSA_SYNC_FILL = 3;

  // Shared pin use, written as {bit 0, bit 1} of configuration four.
  typedef enum logic [1:0] {
    LSA_USE_TACH = 2'h0,
    LSA_USE_THROTTLE = 2'h1,
    LSA_USE_ALERT = 2'h2,
    LSA_USE_GENERAL = 2'h3
  } lsa_use_e;

endpackage : lsa_pkg

// *** hw/lsa_sync.sv ***
// Two-stage synchroniser bank for pins entering the clock domain.
`timescale 1ns/1ps

module lsa_sync #(
  parameter int WIDTH = 8
) (
  input wire logic mclk_in,
  input wire logic rst_b_in,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  // First stage feeds only the second stage.
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      meta_q <= '1;
      sync_q <= '1;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  // Only the second stage is visible outside.
  assign sync_out = sync_q;

endmodule : lsa_sync

// *** bench/lsa_host_model.sv ***
// Host model: register access tasks and the pulled-up alert wire.
`timescale 1ns/1ps
module lsa_host_model (
  input wire logic mclk_in,
  input wire logic [7:0] reg_rdata_in,
  input wire logic drive_in,
  input wire logic drive_oe_in,
  output logic [7:0] reg_addr_out,
  output logic [7:0] reg_wdata_out,
  output logic reg_wr_out,
  output logic reg_rd_out,
  output logic alert_wire_b_out
);
  // The pull-up holds the wire high unless the pin drives it low.
  assign alert_wire_b_out = (drive_oe_in && !drive_in) ? 1'b0 : 1'b1;

  // Idle bus values at time zero.
  initial begin
    reg_addr_out = 8'h00;
    reg_wdata_out = 8'h00;
    reg_wr_out = 1'b0;
    reg_rd_out = 1'b0;
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk_in);
    reg_addr_out = a;
    reg_wdata_out = d;
    reg_wr_out = 1'b1;
    @(negedge mclk_in);
    reg_wr_out = 1'b0;
    reg_addr_out = ~a;
    reg_wdata_out = ~d;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge mclk_in);
    reg_addr_out = a;
    reg_rd_out = 1'b1;
    @(negedge mclk_in);
    reg_rd_out = 1'b0;
    reg_addr_out = ~a;
    d = reg_rdata_in;
  endtask : rd
endmodule : lsa_host_model

// *** bench/lsa_alert_monitor.sv ***
// Port checker for the limit status and alert logic, with its bind.
`timescale 1ns/1ps
module lsa_alert_monitor
  import lsa_pkg::*;
(
  input wire logic mclk_in,
  input wire logic rst_b_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic second_fan_drive_out,
  input wire logic second_fan_drive_oe_out,
  input wire logic shared_general_pin_oe_out,
  input wire logic fan_boost_out,
  input wire logic shared_tach_sel_out
);
  logic [7:0] c3_q;
  logic [7:0] c4_q;
  logic [7:0] m1_q;
  logic [1:0] use_w;
  logic mapped_w;

  // Shadow copies of configuration and first mask taken from writes.
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      c3_q <= 8'h00;
      c4_q <= 8'h00;
      m1_q <= 8'h00;
    end else if (reg_wr_in) begin
      if (reg_addr_in == LSA_OFF_CONFIG_THREE) c3_q <= reg_wdata_in;
      if (reg_addr_in == LSA_OFF_CONFIG_FOUR) c4_q <= reg_wdata_in;
      if (reg_addr_in == LSA_OFF_MASK_FIRST) m1_q <= reg_wdata_in;
    end
  end

  // Shared pin use and the set of decoded offsets.
  assign use_w = {c4_q[0], c4_q[1]};
  assign mapped_w = reg_addr_in inside {LSA_OFF_STATUS_FIRST,
    LSA_OFF_STATUS_SECOND, LSA_OFF_MASK_FIRST, LSA_OFF_MASK_SECOND,
    LSA_OFF_CONFIG_THREE, LSA_OFF_CONFIG_FOUR};

  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (!rst_b_in);

  // A cycle with no host access.
  sequence s_quiet;
    !reg_rd_in && !reg_wr_in;
  endsequence

  // Alert pin selected with every source masked.
  sequence s_all_masked;
    c3_q[0] && m1_q == 8'hff;
  endsequence

  // ********************************************************************
  // Assertions
  // ********************************************************************
  a_mask_readback: assert property (
    reg_rd_in && !reg_wr_in && reg_addr_in == LSA_OFF_MASK_FIRST
    |=> reg_rdata_out == m1_q) else $error("mask readback wrong");
  a_unmapped_zero: assert property (
    reg_rd_in && !mapped_w |=> reg_rdata_out == 8'h00)
    else $error("unmapped read not zero");
  a_alert_holds: assert property (
    s_quiet [*3] ##0 (c3_q[0] && second_fan_drive_oe_out)
    |=> second_fan_drive_oe_out) else $error("alert dropped unread");
  a_mask_silences: assert property (
    s_all_masked [*3] |-> !second_fan_drive_oe_out)
    else $error("masked alert asserted");
  a_alert_pulls_low: assert property (
    c3_q[0] [*2] |-> !second_fan_drive_out)
    else $error("alert pin not open drain low");
  a_boost_needs_bit: assert property (
    !c3_q[2] [*2] |-> !fan_boost_out) else $error("boost while disabled");
  a_tach_select: assert property (
    shared_tach_sel_out == (use_w == LSA_USE_TACH))
    else $error("tach select wrong");
  a_shared_alert_only: assert property (
    shared_general_pin_oe_out |-> $past(use_w) == LSA_USE_ALERT)
    else $error("shared pin driven outside alert use");
endmodule : lsa_alert_monitor

bind lsa_alert lsa_alert_monitor u_mon (
  .mclk_in(mclk_in), .rst_b_in(rst_b_in), .reg_addr_in(reg_addr_in),
  .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
  .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
  .second_fan_drive_out(second_fan_drive_out),
  .second_fan_drive_oe_out(second_fan_drive_oe_out),
  .shared_general_pin_oe_out(shared_general_pin_oe_out),
  .fan_boost_out(fan_boost_out), .shared_tach_sel_out(shared_tach_sel_out)
);

// *** bench/limit_status_alert_logic_test.sv ***
// Self-checking bench for the limit status and alert logic.
`timescale 1ns/1ps
module limit_status_alert_logic_test;
  import lsa_pkg::*;
  localparam logic [7:0] HI = 8'hc0;
  localparam logic [7:0] LO = 8'h40;
  localparam logic [7:0] S1 = LSA_OFF_STATUS_FIRST;
  localparam logic [7:0] S2 = LSA_OFF_STATUS_SECOND;
  localparam logic [7:0] M1 = LSA_OFF_MASK_FIRST;
  localparam logic [7:0] M2 = LSA_OFF_MASK_SECOND;
  localparam logic [7:0] C3 = LSA_OFF_CONFIG_THREE;
  localparam logic [7:0] C4 = LSA_OFF_CONFIG_FOUR;
  logic clk = 1'b0, rst_b = 1'b0, mv = 1'b0, vsel = 1'b0, man = 1'b1;
  logic hot = 1'b0, pwm = 1'b0, th_b = 1'b1, gp = 1'b1;
  logic [2:0] ch = 3'h0;
  logic [7:0] val = 8'h80, lv = 8'h00, tmr = 8'h00, duty = 8'h40;
  logic [5:0] vid = 6'h00;
  logic [7:0] addr, wdat, rdat;
  logic wr, rd, drv, drv_oe, gp_o, gp_oe, boost, tach, alert_b;
  logic [7:0] offs [6] = '{S1, S2, M1, M2, C3, C4};
  int miscompares = 0;
  int n_compared = 0;

  // System clock and the free-running fan drive level.
  always #2.5 clk = ~clk;
  always #32 pwm = ~pwm;

  lsa_alert dut (
    .mclk_in(clk), .rst_b_in(rst_b), .reg_addr_in(addr), .reg_wr_in(wr),
    .reg_rd_in(rd), .reg_wdata_in(wdat), .reg_rdata_out(rdat),
    .meas_valid_in(mv), .meas_chan_in(ch), .meas_value_in(val),
    .meas_high_in(HI), .meas_low_in(LO), .diode_two_fault_in(lv[7]),
    .diode_one_fault_in(lv[6]), .fan_four_slow_in(lv[5]),
    .fan_three_slow_in(lv[4]), .fan_two_slow_in(lv[3]),
    .fan_one_slow_in(lv[2]), .critical_overtemp_in(lv[1]),
    .vid_change_select_in(vsel), .throttle_timer_in(tmr),
    .throttle_limit_in(8'h10), .manual_mode_in(man), .manual_duty_in(duty),
    .temp_above_tmin_in(hot), .second_fan_pwm_in(pwm),
    .thermal_throttle_pin_in(th_b), .shared_general_pin_in(gp),
    .voltage_id_input_in(vid), .second_fan_drive_out(drv),
    .second_fan_drive_oe_out(drv_oe), .shared_general_pin_out(gp_o),
    .shared_general_pin_oe_out(gp_oe), .fan_boost_out(boost),
    .shared_tach_sel_out(tach)
  );

  lsa_host_model host (
    .mclk_in(clk), .reg_rdata_in(rdat), .drive_in(drv), .drive_oe_in(drv_oe),
    .reg_addr_out(addr), .reg_wdata_out(wdat), .reg_wr_out(wr),
    .reg_rd_out(rd), .alert_wire_b_out(alert_b)
  );

  // Compares one value and counts the result.
  task automatic chk(input string nm, input logic [7:0] got,
                     input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask : chk

  // Reads a register and compares it.
  task automatic rc(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] v;
    host.rd(a, v);
    chk($sformatf("reg %h", a), v, exp);
  endtask : rc

  // Waits a number of falling edges.
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc

  // Hands one finished measurement to the block.
  task automatic meas(input logic [2:0] c, input logic [7:0] v);
    @(negedge clk);
    ch = c;
    val = v;
    mv = 1'b1;
    @(negedge clk);
    mv = 1'b0;
  endtask : meas

  // Pulses the level conditions for two cycles.
  task automatic lvl(input logic [7:0] b);
    lv = b;
    cyc(2);
    lv = 8'h00;
  endtask : lvl

  // Checks the alert wire after three cycles of settling.
  task automatic ac(input logic e);
    cyc(3);
    chk("alert wire", {7'h00, alert_b}, {7'h00, e});
  endtask : ac

  // Checks the boost output after the pin settles.
  task automatic bc(input int n, input logic e);
    cyc(n);
    chk("boost", {7'h00, boost}, {7'h00, e});
  endtask : bc

  // Prints the counts and the verdict, then ends the run.
  task automatic summarize;
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : summarize

  // Main test sequence.
  initial begin
    cyc(3);
    rst_b = 1'b1;
    foreach (offs[i]) rc(offs[i], LSA_RST_BYTE);
    host.wr(8'h10, 8'h5a);
    rc(8'h10, 8'h00);
    host.wr(M1, 8'ha5);
    host.wr(M2, 8'h5a);
    rc(M1, 8'ha5);
    rc(M2, 8'h5a);
    host.wr(M1, 8'h00);
    host.wr(M2, 8'h00);
    $display("test registers done");
    for (int c = 0; c < 8; c++) begin
      meas(3'(c), LO);
      meas(3'(c), HI);
      rc(S1, c == 7 ? 8'h80 : 8'(1 << c));
      rc(S2, c == 7 ? 8'h01 : 8'h00);
      rc(S1, 8'h00);
    end
    meas(3'h3, HI + 8'h01);
    rc(S1, 8'h08);
    rc(S1, 8'h08);
    meas(3'h3, 8'h80);
    rc(S1, 8'h08);
    rc(S1, 8'h00);
    $display("test channels done");
    for (int b = 1; b < 8; b++) begin
      lvl(8'(1 << b));
      rc(S1, 8'h80);
      rc(S2, 8'(1 << b));
      rc(S2, 8'h00);
    end
    vsel = 1'b1;
    vid = 6'h2a;
    cyc(4);
    rc(S2, 8'h01);
    rc(S2, 8'h00);
    vsel = 1'b0;
    $display("test levels done");
    host.wr(C3, 8'h01);
    ac(1'b1);
    meas(3'h2, LO);
    meas(3'h2, HI);
    ac(1'b0);
    rc(S1, 8'h04);
    ac(1'b1);
    host.wr(M1, 8'hff);
    meas(3'h2, LO);
    meas(3'h2, HI);
    lvl(8'h04);
    ac(1'b1);
    rc(S1, 8'h84);
    rc(S2, 8'h04);
    host.wr(M1, 8'h00);
    host.wr(M2, 8'h04);
    lvl(8'h04);
    ac(1'b1);
    rc(S2, 8'h04);
    host.wr(M2, 8'h00);
    $display("test alert done");
    host.wr(C3, 8'h06);
    th_b = 1'b0;
    bc(4, 1'b1);
    chk("drive oe", {7'h00, drv_oe}, 8'h01);
    th_b = 1'b1;
    bc(4, 1'b0);
    rc(S1, 8'h01);
    rc(S1, 8'h00);
    duty = 8'h00;
    th_b = 1'b0;
    bc(4, 1'b0);
    man = 1'b0;
    bc(2, 1'b0);
    hot = 1'b1;
    bc(2, 1'b1);
    th_b = 1'b1;
    cyc(4);
    rc(S1, 8'h01);
    rc(S1, 8'h00);
    $display("test boost done");
    for (int u = 0; u < 4; u++) begin
      host.wr(C4, {6'h00, u[0], u[1]});
      chk("tach select", {7'h00, tach}, u == 0 ? 8'h01 : 8'h00);
    end
    gp = 1'b0;
    cyc(4);
    rc(S2, 8'h20);
    rc(S2, 8'h00);
    host.wr(C4, 8'h02);
    gp = 1'b1;
    tmr = 8'h11;
    cyc(2);
    tmr = 8'h10;
    cyc(2);
    rc(S2, 8'h20);
    rc(S2, 8'h00);
    host.wr(C4, 8'h01);
    lvl(8'h04);
    cyc(2);
    chk("shared oe", {7'h00, gp_oe}, 8'h01);
    chk("shared out", {7'h00, gp_o}, 8'h00);
    rc(S2, 8'h04);
    cyc(3);
    chk("shared oe", {7'h00, gp_oe}, 8'h00);
    $display("test shared pin done");
    summarize();
  end

  // Watchdog that cuts a hung run short.
  initial begin
    #200000;
    miscompares++;
    summarize();
  end
endmodule : limit_status_alert_logic_test
